//--- verilog/rtc_nvram_pkg.sv
// Shared constants, register layout and time record for the byte-wide clock RAM
package rtc_nvram_pkg;

    // ==========================================================
    // Timing
    localparam int unsigned CLK_PERIOD_NS     = 10;
    localparam int unsigned SEC_NS            = 1_000_000_000;
    localparam int unsigned PROBE_HZ          = 512;
    localparam int unsigned SEC_CYCLES        = SEC_NS / CLK_PERIOD_NS;
    // Half period of the test toggle, rounded down to whole cycles
    localparam int unsigned PROBE_HALF_CYCLES = SEC_CYCLES / (2 * PROBE_HZ);

    // ==========================================================
    // Memory geometry and clock register offsets
    localparam int unsigned ADDR_WIDTH = 15;
    localparam logic [14:0] ADDR_CTRL  = 15'h7ff8;
    localparam logic [14:0] ADDR_SEC   = 15'h7ff9;
    localparam logic [14:0] ADDR_MIN   = 15'h7ffa;
    localparam logic [14:0] ADDR_HOUR  = 15'h7ffb;
    localparam logic [14:0] ADDR_DAY   = 15'h7ffc;
    localparam logic [14:0] ADDR_DATE  = 15'h7ffd;
    localparam logic [14:0] ADDR_MONTH = 15'h7ffe;
    localparam logic [14:0] ADDR_YEAR  = 15'h7fff;

    // ==========================================================
    // Field positions
    localparam int unsigned CTRL_WFREEZE_BIT = 7;
    localparam int unsigned CTRL_RFREEZE_BIT = 6;
    localparam int unsigned SEC_STOP_BIT     = 7;
    localparam int unsigned DAY_HEALTH_BIT   = 7;
    localparam int unsigned DAY_PROBE_BIT    = 6;

    // ==========================================================
    // Time record; packed so that byte i sits at clock offset i
    typedef struct packed {
        logic [7:0] year;
        logic [7:0] month;
        logic [7:0] date;
        logic [7:0] day;
        logic [7:0] hour;
        logic [7:0] min;
        logic [7:0] sec;
        logic [7:0] century;
    } time_t;

    // Bits that hold count value in each byte; the rest stay zero
    localparam time_t VALUE_MASK = '{year: 8'hff, month: 8'h1f, date: 8'h3f, day: 8'h07,
                                     hour: 8'h3f, min: 8'h7f, sec: 8'h7f, century: 8'h3f};
    localparam time_t TIME_RESET = '{year: 8'h00, month: 8'h01, date: 8'h01, day: 8'h01,
                                     hour: 8'h00, min: 8'h00, sec: 8'h00, century: 8'h20};

    // Host pin group
    typedef struct packed {
        logic        ce_n;
        logic        oe_n;
        logic        we_n;
        logic [14:0] addr;
        logic [7:0]  data;
    } host_pins_t;

endpackage

//--- verilog/rtc_nvram.sv
// Byte-wide static RAM with a BCD real-time clock in its top eight bytes
`timescale 1ns/1ps
module rtc_nvram #(
    parameter int unsigned ADDR_W     = rtc_nvram_pkg::ADDR_WIDTH,
    parameter int unsigned SEC_CYC    = rtc_nvram_pkg::SEC_CYCLES,
    parameter int unsigned PROBE_HALF = rtc_nvram_pkg::PROBE_HALF_CYCLES
) (
    input  wire logic              core_clk_i,
    input  wire logic              nrst_i,
    input  wire logic              ce_n_i,
    input  wire logic              oe_n_i,
    input  wire logic              we_n_i,
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [7:0]        dq_i,
    input  wire logic              vcc_ok_i,
    input  wire logic              cell_good_i,
    output logic      [7:0]        dq_o,
    output logic                   dq_oe_o,
    output logic                   pf_rst_n_o,
    output logic                   pf_rst_oe_o
);

    // ==========================================================
    // Calendar helpers
    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
    endfunction

    function automatic logic [7:0] month_end(input logic [7:0] mon, input logic [7:0] yr);
        logic [1:0] rem;
        // (10t + u) mod 4 equals (2t + u) mod 4
        rem = {yr[4], 1'b0} + yr[1:0];
        case (mon)
            8'h02: month_end = (rem == 2'b00) ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11: month_end = 8'h30;
            default: month_end = 8'h31;
        endcase
    endfunction

    function automatic rtc_nvram_pkg::time_t next_time(input rtc_nvram_pkg::time_t t);
        rtc_nvram_pkg::time_t n;
        n = t;
        if (t.sec != 8'h59) begin
            n.sec = bcd_inc(t.sec);
        end else begin
            n.sec = 8'h00;
            if (t.min != 8'h59) begin
                n.min = bcd_inc(t.min);
            end else begin
                n.min = 8'h00;
                if (t.hour != 8'h23) begin
                    n.hour = bcd_inc(t.hour);
                end else begin
                    n.hour = 8'h00;
                    n.day  = (t.day == 8'h07) ? 8'h01 : t.day + 8'h01;
                    if (t.date != month_end(t.month, t.year)) begin
                        n.date = bcd_inc(t.date);
                    end else begin
                        n.date = 8'h01;
                        if (t.month != 8'h12) begin
                            n.month = bcd_inc(t.month);
                        end else begin
                            n.month = 8'h01;
                            if (t.year != 8'h99) begin
                                n.year = bcd_inc(t.year);
                            end else begin
                                n.year    = 8'h00;
                                n.century = (t.century == 8'h39) ? 8'h00 : bcd_inc(t.century);
                            end
                        end
                    end
                end
            end
        end
        next_time = n;
    endfunction

    // ==========================================================
    // State
    logic [7:0]           ram_mem [2**ADDR_W];
    rtc_nvram_pkg::time_t cnt_ff;
    rtc_nvram_pkg::time_t vis_ff;
    logic                 wfreeze_ff;
    logic                 rfreeze_ff;
    logic                 crystal_stop_ff;
    logic                 rate_probe_ff;
    logic                 probe_tog_ff;
    logic [31:0]          sec_div_ff;
    logic [31:0]          probe_div_ff;
    logic                 wr_act_ff;
    logic [ADDR_W-1:0]    wa_ff;
    logic [7:0]           wd_ff;

    // ==========================================================
    // Pin decode
    wire       rd_cond   = !ce_n_i && !oe_n_i && we_n_i && vcc_ok_i;
    wire       wr_active = !ce_n_i && !we_n_i && vcc_ok_i;
    // Committing at the end lets the host settle data as late as the strobe edge
    wire       wr_end    = wr_act_ff && !wr_active;
    wire       clk_hit_w = &wa_ff[ADDR_W-1:3];
    wire [2:0] widx      = wa_ff[2:0];
    wire       clk_hit_r = &addr_i[ADDR_W-1:3];
    wire [2:0] ridx      = addr_i[2:0];

    wire ctrl_wr     = wr_end && clk_hit_w && (widx == rtc_nvram_pkg::ADDR_CTRL[2:0]);
    wire sec_wr      = wr_end && clk_hit_w && (widx == rtc_nvram_pkg::ADDR_SEC[2:0]);
    wire day_wr      = wr_end && clk_hit_w && (widx == rtc_nvram_pkg::ADDR_DAY[2:0]);
    wire sets_freeze = ctrl_wr && (wd_ff[rtc_nvram_pkg::CTRL_WFREEZE_BIT]
                                   || wd_ff[rtc_nvram_pkg::CTRL_RFREEZE_BIT]);
    // Load into the counters only when leaving the write freeze
    wire xfer        = ctrl_wr && wfreeze_ff
                       && !wd_ff[rtc_nvram_pkg::CTRL_WFREEZE_BIT];
    wire vis_wr      = wr_end && clk_hit_w && wfreeze_ff && !ctrl_wr;
    wire frozen      = wfreeze_ff || rfreeze_ff;
    wire sec_tick    = !crystal_stop_ff && (sec_div_ff == SEC_CYC - 1);
    wire probe_on    = rate_probe_ff && !crystal_stop_ff;

    // ==========================================================
    // Read data path
    wire [7:0] vis_byte = vis_ff[{ridx, 3'b000} +: 8];
    wire [7:0] ctrl_rd  = {wfreeze_ff, rfreeze_ff, vis_byte[5:0]};
    wire [7:0] sec_rd   = {crystal_stop_ff, vis_byte[6:1],
                           probe_on ? probe_tog_ff : vis_byte[0]};
    wire [7:0] day_rd   = {cell_good_i, rate_probe_ff, 3'b000, vis_byte[2:0]};
    wire [7:0] clk_rd   = (ridx == rtc_nvram_pkg::ADDR_CTRL[2:0]) ? ctrl_rd :
                          (ridx == rtc_nvram_pkg::ADDR_SEC[2:0])  ? sec_rd  :
                          (ridx == rtc_nvram_pkg::ADDR_DAY[2:0])  ? day_rd  : vis_byte;
    wire [7:0] rd_byte  = clk_hit_r ? clk_rd : ram_mem[addr_i];

    // ==========================================================
    // Host strobes and outputs
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wr_act_ff   <= 1'b0;
            wa_ff       <= '0;
            wd_ff       <= 8'h00;
            dq_o        <= 8'h00;
            dq_oe_o     <= 1'b0;
            pf_rst_n_o  <= 1'b0;
            pf_rst_oe_o <= 1'b1;
        end else begin
            wr_act_ff   <= wr_active;
            if (wr_active) begin
                wa_ff <= addr_i;
                wd_ff <= dq_i;
            end
            // Write enable low cuts the drive one cycle after the read data showed
            dq_oe_o     <= rd_cond;
            dq_o        <= rd_cond ? rd_byte : 8'h00;
            pf_rst_n_o  <= 1'b0;
            pf_rst_oe_o <= !vcc_ok_i;
        end
    end

    // Array has no reset: contents are meant to survive
    always_ff @(posedge core_clk_i) begin
        if (wr_end && !clk_hit_w) begin
            ram_mem[wa_ff] <= wd_ff;
        end
    end

    // ==========================================================
    // Control bits
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wfreeze_ff      <= 1'b0;
            rfreeze_ff      <= 1'b0;
            crystal_stop_ff <= 1'b0;
            rate_probe_ff   <= 1'b0;
        end else begin
            if (ctrl_wr) begin
                wfreeze_ff <= wd_ff[rtc_nvram_pkg::CTRL_WFREEZE_BIT];
                rfreeze_ff <= wd_ff[rtc_nvram_pkg::CTRL_RFREEZE_BIT];
            end
            if (sec_wr) begin
                crystal_stop_ff <= wd_ff[rtc_nvram_pkg::SEC_STOP_BIT];
            end
            if (day_wr) begin
                rate_probe_ff <= wd_ff[rtc_nvram_pkg::DAY_PROBE_BIT];
            end
        end
    end

    // ==========================================================
    // Timebase dividers
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sec_div_ff   <= 32'h0000_0000;
            probe_div_ff <= 32'h0000_0000;
            probe_tog_ff <= 1'b0;
        end else begin
            if (crystal_stop_ff || sec_tick) begin
                sec_div_ff <= 32'h0000_0000;
            end else begin
                sec_div_ff <= sec_div_ff + 32'h0000_0001;
            end
            if (!probe_on || probe_div_ff == PROBE_HALF - 1) begin
                probe_div_ff <= 32'h0000_0000;
            end else begin
                probe_div_ff <= probe_div_ff + 32'h0000_0001;
            end
            if (probe_on && probe_div_ff == PROBE_HALF - 1) begin
                probe_tog_ff <= !probe_tog_ff;
            end
        end
    end

    // ==========================================================
    // Hidden counters and visible copy
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt_ff <= rtc_nvram_pkg::TIME_RESET;
            vis_ff <= rtc_nvram_pkg::TIME_RESET;
        end else begin
            if (xfer) begin
                cnt_ff         <= vis_ff & rtc_nvram_pkg::VALUE_MASK;
                cnt_ff.century <= wd_ff & rtc_nvram_pkg::VALUE_MASK.century;
            end else if (sec_tick) begin
                cnt_ff <= next_time(cnt_ff);
            end
            // Century changes only through a write-freeze exit or a year 99 rollover, so R writes cannot touch it
            if (!frozen) begin
                vis_ff <= cnt_ff;
            end else if (vis_wr) begin
                vis_ff[{widx, 3'b000} +: 8] <= wd_ff;
            end
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!nrst_i);

    chk_freeze_holds_view: assert property (
        rfreeze_ff && $past(rfreeze_ff) && !wfreeze_ff |-> $stable(vis_ff))
        else $error("visible time moved during read freeze");
    chk_count_keeps_running: assert property (
        rfreeze_ff && sec_tick && !xfer |=> cnt_ff != $past(cnt_ff))
        else $error("hidden count stalled during freeze");
    chk_view_refresh: assert property (
        !wfreeze_ff && !rfreeze_ff |=> vis_ff == $past(cnt_ff))
        else $error("visible time not refreshed from count");
    chk_set_transfer: assert property (
        xfer |=> cnt_ff.min == ($past(vis_ff.min) & rtc_nvram_pkg::VALUE_MASK.min))
        else $error("set values not moved into count");
    chk_century_kept: assert property (
        sets_freeze && !sec_tick |=> $stable(cnt_ff.century))
        else $error("century changed by freeze write");
    chk_century_loaded: assert property (
        xfer |=> cnt_ff.century == ($past(wd_ff) & rtc_nvram_pkg::VALUE_MASK.century))
        else $error("century not loaded on write freeze exit");
    chk_century_read_exit: assert property (
        ctrl_wr && rfreeze_ff && !wfreeze_ff && !sec_tick |=> $stable(cnt_ff.century))
        else $error("century changed on read freeze exit");
    chk_crystal_halt: assert property (
        crystal_stop_ff && !xfer |=> $stable(cnt_ff) && sec_div_ff == 32'h0000_0000)
        else $error("time advanced with crystal stopped");
    chk_probe_on_line: assert property (
        rd_cond && clk_hit_r && ridx == rtc_nvram_pkg::ADDR_SEC[2:0] && probe_on
        |=> dq_o[0] == $past(probe_tog_ff))
        else $error("probe toggle not on data line zero");
    chk_read_drive: assert property (
        rd_cond |=> dq_oe_o && dq_o == $past(rd_byte))
        else $error("read data not driven");
    chk_write_release: assert property (
        !we_n_i && !ce_n_i |=> !dq_oe_o)
        else $error("data pins driven during write");
    chk_power_fail: assert property (
        !vcc_ok_i |=> pf_rst_oe_o && !dq_oe_o ##0 !wr_act_ff)
        else $error("access not blocked below threshold");

    cov_read_freeze_exit: cover property (rfreeze_ff ##1 !rfreeze_ff ##1 vis_ff == $past(cnt_ff));
    cov_clock_set: cover property (vis_wr ##[1:20] xfer);
    cov_probe_read: cover property ((rd_cond && probe_on && clk_hit_r) [*3]);

endmodule // rtc_nvram

//--- sim/host_model.sv
// Host model: asynchronous byte-wide bus master for the clock RAM
`timescale 1ns/1ps
module host_model (
    input  wire logic                core_clk_i,
    output rtc_nvram_pkg::host_pins_t pins_o
);
    // ==========================================================
    // Idle bus: strobes high
    initial begin
        pins_o = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: 15'h0000, data: 8'h00};
    end

    // ==========================================================
    // Every task is entered at a falling edge and returns at one
    task automatic wr(input logic [14:0] a, input logic [7:0] d);
        pins_o.addr = a;
        pins_o.data = d;
        pins_o.oe_n = 1'b1;
        pins_o.ce_n = 1'b0;
        pins_o.we_n = 1'b0;
        @(negedge core_clk_i);
        // Strobes rise for a full cycle so writes never merge; address stays put
        pins_o.ce_n = 1'b1;
        pins_o.we_n = 1'b1;
        pins_o.data = ~d;
        @(negedge core_clk_i);
    endtask

    // Read stays open so that further calls ripple through new addresses
    task automatic rd(input logic [14:0] a);
        pins_o.addr = a;
        pins_o.we_n = 1'b1;
        pins_o.ce_n = 1'b0;
        pins_o.oe_n = 1'b0;
        @(negedge core_clk_i);
    endtask

    // Lowers write enable under an open read; the caller ends the write with done()
    task automatic wr_in_read(input logic [7:0] d);
        pins_o.data = d;
        pins_o.we_n = 1'b0;
        @(negedge core_clk_i);
    endtask

    task automatic done();
        pins_o.ce_n = 1'b1;
        pins_o.oe_n = 1'b1;
        pins_o.we_n = 1'b1;
        @(negedge core_clk_i);
    endtask
endmodule // host_model

//--- sim/testbench.sv
// Self-checking bench for the byte-wide clock RAM
`timescale 1ns/1ps
module testbench;
    localparam int unsigned SEC = 100;

    logic                       core_clk_i;
    logic                       nrst_i;
    logic                       vcc_ok_i;
    logic                       cell_good_i;
    logic [7:0]                 dq_o;
    logic                       dq_oe_o;
    logic                       pf_rst_n_o;
    logic                       pf_rst_oe_o;
    rtc_nvram_pkg::host_pins_t  pins;
    logic [7:0]                 exp_q[$];
    int                         fails;
    int                         n_compared;
    int                         seed;
    rtc_nvram_pkg::time_t       start_t[2];
    rtc_nvram_pkg::time_t       next_t[2];
    logic [14:0]                ram_a[8];
    logic [7:0]                 ram_d[8];
    logic                       prev;

    host_model host (.core_clk_i(core_clk_i), .pins_o(pins));

    rtc_nvram #(.SEC_CYC(SEC), .PROBE_HALF(4)) uut (
        .core_clk_i(core_clk_i), .nrst_i(nrst_i), .ce_n_i(pins.ce_n), .oe_n_i(pins.oe_n),
        .we_n_i(pins.we_n), .addr_i(pins.addr), .dq_i(pins.data), .vcc_ok_i(vcc_ok_i),
        .cell_good_i(cell_good_i), .dq_o(dq_o), .dq_oe_o(dq_oe_o), .pf_rst_n_o(pf_rst_n_o),
        .pf_rst_oe_o(pf_rst_oe_o)
    );

    // ==========================================================
    // Checking
    task automatic chk_byte(input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: expected %h got %h", $time, exp, got);
        end
    endtask

    task automatic chk_bit(input logic exp, input logic got);
        chk_byte({7'h00, exp}, {7'h00, got});
    endtask

    task automatic give_verdict();
        if (fails == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // A read answer is one cycle of driven data; compare it with the oldest note
    always @(negedge core_clk_i) begin
        if (dq_oe_o === 1'b1 && exp_q.size() > 0) begin
            chk_byte(exp_q.pop_front(), dq_o);
        end
    end

    task automatic rx(input logic [14:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        host.rd(a);
        host.done();
    endtask

    // All eight clock bytes; called only while the crystal is stopped
    task automatic rx_all(input rtc_nvram_pkg::time_t t);
        logic [7:0] e;
        for (int i = 0; i < 8; i++) begin
            e = t[i*8 +: 8];
            if (i == 1) e[7] = 1'b1;
            if (i == 4) e[7] = cell_good_i;
            rx(rtc_nvram_pkg::ADDR_CTRL + 15'(i), e);
        end
    endtask

    // ==========================================================
    // Clock, watchdog and main sequence
    initial begin
        core_clk_i = 1'b0;
        forever #5 core_clk_i = ~core_clk_i;
    end

    initial begin
        repeat (90000) @(posedge core_clk_i);
        fails++;
        give_verdict();
    end

    initial begin
        seed = 45947;
        nrst_i = 1'b0;
        vcc_ok_i = 1'b1;
        cell_good_i = 1'b1;
        start_t[0] = 64'h99_12_31_07_23_59_59_19;
        next_t[0] = 64'h00_01_01_01_00_00_00_20;
        start_t[1] = 64'h00_02_28_02_23_59_59_20;
        next_t[1] = 64'h00_02_29_03_00_00_00_20;
        repeat (20) @(negedge core_clk_i);
        nrst_i = 1'b1;
        @(negedge core_clk_i);
        // Crystal stopped first so no tick lands between the reads
        host.wr(rtc_nvram_pkg::ADDR_SEC, 8'h80);
        rx_all(rtc_nvram_pkg::TIME_RESET);
        for (int c = 0; c < 2; c++) begin
            host.wr(rtc_nvram_pkg::ADDR_CTRL, 8'h80);
            for (int i = 1; i < 8; i++) begin
                host.wr(rtc_nvram_pkg::ADDR_CTRL + 15'(i),
                        start_t[c][i*8 +: 8] | ((i == 1) ? 8'h80 : 8'h00));
            end
            host.wr(rtc_nvram_pkg::ADDR_CTRL, start_t[c].century);
            // Divider starts from zero, so exactly one tick fits before the stop
            host.wr(rtc_nvram_pkg::ADDR_SEC, 8'h00);
            repeat (SEC + 20) @(negedge core_clk_i);
            host.wr(rtc_nvram_pkg::ADDR_SEC, 8'h80);
            repeat (150) @(negedge core_clk_i);
            rx_all(next_t[c]);
        end
        host.wr(rtc_nvram_pkg::ADDR_SEC, 8'h00);
        host.wr(rtc_nvram_pkg::ADDR_CTRL, 8'h51);
        repeat (250) @(negedge core_clk_i);
        rx(rtc_nvram_pkg::ADDR_SEC, 8'h00);
        rx(rtc_nvram_pkg::ADDR_CTRL, 8'h60);
        host.wr(rtc_nvram_pkg::ADDR_CTRL, 8'h13);
        repeat (50000) @(negedge core_clk_i);
        rx(rtc_nvram_pkg::ADDR_MIN, 8'h08);
        rx(rtc_nvram_pkg::ADDR_SEC, 8'h22);
        rx(rtc_nvram_pkg::ADDR_CTRL, 8'h20);
        host.wr(rtc_nvram_pkg::ADDR_DAY, 8'h40);
        host.rd(rtc_nvram_pkg::ADDR_SEC);
        for (int k = 0; k < 6; k++) begin
            prev = dq_o[0];
            repeat (4) @(negedge core_clk_i);
            chk_bit(~prev, dq_o[0]);
        end
        host.done();
        rx(rtc_nvram_pkg::ADDR_DAY, 8'hc3);
        cell_good_i = 1'b0;
        rx(rtc_nvram_pkg::ADDR_DAY, 8'h43);
        for (int i = 0; i < 8; i++) begin
            ram_a[i] = {1'b0, 3'(i), 11'($random(seed))};
            ram_d[i] = 8'($random(seed));
            host.wr(ram_a[i], ram_d[i]);
        end
        foreach (ram_d[i]) exp_q.push_back(ram_d[i]);
        foreach (ram_a[i]) host.rd(ram_a[i]);
        host.done();
        // Write entered with output enable already low: read data first, then release
        exp_q.push_back(ram_d[1]);
        host.rd(ram_a[1]);
        host.wr_in_read(~ram_d[1]);
        chk_bit(1'b0, dq_oe_o);
        host.done();
        rx(ram_a[1], ~ram_d[1]);
        vcc_ok_i = 1'b0;
        repeat (2) @(negedge core_clk_i);
        chk_bit(1'b1, pf_rst_oe_o);
        chk_bit(1'b0, pf_rst_n_o);
        host.wr(ram_a[0], ~ram_d[0]);
        host.rd(ram_a[0]);
        chk_bit(1'b0, dq_oe_o);
        host.done();
        vcc_ok_i = 1'b1;
        repeat (2) @(negedge core_clk_i);
        chk_bit(1'b0, pf_rst_oe_o);
        rx(ram_a[0], ram_d[0]);
        for (int w = 0; w < 10 && exp_q.size() > 0; w++) @(negedge core_clk_i);
        if (exp_q.size() > 0) fails++;
        give_verdict();
    end
endmodule // testbench
